// ==== dv/atsrf_host.sv ====
// host model for the serial programming port of the forwarder
// assumes core_clk paces it: one serial bit every 8 core cycles
`timescale 1ns/1ps
module atsrf_host (
    input  wire logic core_clk,
    output logic      serial_clk,
    output logic      serial_en_n,
    output logic      serial_data
);
    initial begin
        serial_clk  = 1'b0;
        serial_en_n = 1'b1;
        serial_data = 1'b0;
    end

    // address byte, then nw words taken from the top of dat
    task automatic write(input logic [7:0] a, input logic [47:0] dat,
                         input int nw);
        logic [55:0] f;
        f = {a, dat};
        @(posedge core_clk);
        serial_en_n <= 1'b0;
        for (int i = 55; i > 47 - 16 * nw; i--) begin
            serial_clk  <= 1'b0;
            serial_data <= f[i];
            repeat (4) @(posedge core_clk);
            serial_clk <= 1'b1;
            repeat (4) @(posedge core_clk);
        end
        serial_clk <= 1'b0;
        repeat (4) @(posedge core_clk);
        serial_en_n <= 1'b1;
        // released line holds no real value, so show the inverse
        serial_data <= ~serial_data;
        repeat (20) @(posedge core_clk);
    endtask
endmodule

// ==== dv/atsrf_top_test.sv ====
// self-checking bench for the attenuator shadow register forwarder
// assumes the host model drives the serial port; link watched here
`timescale 1ns/1ps
module atsrf_top_test;
    import atsrf_pkg::*;
    logic        core_clk = 1'b0;
    logic        sys_rst  = 1'b1;
    logic        pin_n    = 1'b1;
    logic        serial_clk, serial_en_n, serial_data;
    logic        sck, sdat, cs, busy, coding, noise;
    logic [15:0] gain_a, gain_b;
    logic [39:0] got, last;
    logic        sck_q    = 1'b0;
    int          nbits = 0, nwords = 0, n_mismatch = 0, samples_checked = 0;

    always #25 core_clk = ~core_clk;

    atsrf_host i_atsrf_host (.core_clk(core_clk), .serial_clk(serial_clk),
        .serial_en_n(serial_en_n), .serial_data(serial_data));
    atsrf_top i_atsrf_top (.core_clk(core_clk), .sys_rst(sys_rst),
        .serial_clk(serial_clk), .serial_en_n(serial_en_n),
        .serial_data(serial_data), .hardware_reset_pin_n(pin_n),
        .attenuator_serial_clock(sck), .attenuator_serial_data(sdat),
        .attenuator_chip_select(cs), .attenuator_busy(busy),
        .twos_complement_coding(coding), .noise_suppress_en(noise),
        .digital_gain_a(gain_a), .digital_gain_b(gain_b));

    // ------------------------------------------------------------
    // link monitor and helpers
    // ------------------------------------------------------------
    task automatic fail(input string m);
        n_mismatch++;
        $display("Error %0t %s", $time, m);
    endtask

    task automatic chk(input logic [39:0] g, input logic [39:0] e,
                       input string m);
        samples_checked++;
        if (g !== e)
            fail($sformatf("%s got %h exp %h", m, g, e));
    endtask

    always @(posedge core_clk) begin
        if (sck && !sck_q) begin
            samples_checked++;
            if (busy !== 1'b1 || cs !== 1'b0)
                fail("link clock outside a transfer");
            got = {sdat, got[39:1]};
            nbits++;
            if (nbits == 40) begin
                last = got;
                nwords++;
                nbits = 0;
            end
        end
        sck_q = sck;
    end

    // queued resends leave busy low only briefly, so wait for real quiet
    task automatic settle();
        int q;
        q = 0;
        for (int t = 0; t < 3000 && q < 12; t++) begin
            @(posedge core_clk);
            q = (busy === 1'b0) ? q + 1 : 0;
        end
        if (q < 12)
            fail("link never went quiet");
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        i_atsrf_host.write(a, {d, 32'h0}, 1);
        settle();
    endtask

    task automatic word_is(input int n0, input logic [39:0] e);
        chk(40'(nwords - n0), 40'h1, "transfer count");
        chk(last, e, "link word");
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic tc_single();
        chk(40'(nwords), 40'h0, "idle link");
        wr(ADDR_WORD_MID, 16'hA5C3);
        word_is(0, 40'h00_A5C3_0023);
    endtask

    task automatic tc_force();
        int n0;
        n0 = nwords;
        wr(ADDR_WORD_LOW, 16'h1240);
        word_is(n0, 40'h00_A5C3_1243);
        n0 = nwords;
        wr(ADDR_WORD_LOW, 16'h1240);
        chk(40'(nwords - n0), 40'h0, "unchanged write sent");
    endtask

    task automatic tc_burst();
        int n0;
        n0 = nwords;
        i_atsrf_host.write(ADDR_WORD_LOW, 48'h5678_9ABC_00EE, 3);
        settle();
        chk(40'(nwords - n0 >= 2), 40'h1, "no queued resend");
        chk(last, 40'hEE_9ABC_567B, "burst word");
    endtask

    task automatic tc_link();
        int n0;
        wr(ADDR_LINK_RST, 16'h0020);
        chk(40'(cs), 40'h1, "select after link reset bit");
        n0 = nwords;
        wr(ADDR_WORD_MID, 16'hFFFF);
        chk(40'(nwords - n0), 40'h0, "link active in reset");
        chk(40'(cs), 40'h1, "select left reset");
        wr(ADDR_LINK_RST, 16'h0000);
        chk(40'(cs), 40'h0, "select after clear");
        n0 = nwords;
        wr(ADDR_WORD_MID, 16'h0001);
        word_is(n0, 40'h00_0001_0023);
    endtask

    task automatic tc_pin();
        int n0;
        pin_n <= 1'b0;
        repeat (8) @(posedge core_clk);
        chk(40'(cs), 40'h1, "select during pin reset");
        pin_n <= 1'b1;
        settle();
        chk(40'(cs), 40'h0, "select after pin reset");
        n0 = nwords;
        wr(ADDR_WORD_HIGH, 16'h00FF);
        word_is(n0, 40'hFF_0000_0023);
    endtask

    task automatic tc_soft();
        int n0;
        wr(ADDR_SOFT_RST, 16'h0001);
        n0 = nwords;
        wr(ADDR_WORD_MID, 16'h2222);
        word_is(n0, 40'h00_2222_0023);
    endtask

    task automatic tc_misc();
        chk(40'({coding, noise}), 40'h0, "mode defaults");
        chk({gain_a, gain_b, 8'h00}, 40'h0, "gain defaults");
        wr(ADDR_CODING, 16'h0004);
        chk(40'({coding, noise}), 40'h2, "coding select");
        wr(ADDR_NOISE, 16'h0001);
        chk(40'({coding, noise}), 40'h3, "noise select");
        wr(ADDR_GAIN_A, 16'h1234);
        wr(ADDR_GAIN_B, 16'hC0C0);
        chk({gain_a, gain_b, 8'h00}, 40'h1234_C0C0_00, "gains");
    endtask

    task automatic report_and_stop();
        $display("n_mismatch=%0d samples_checked=%0d", n_mismatch,
                 samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge core_clk);
        tc_single();
        tc_force();
        tc_burst();
        tc_link();
        tc_pin();
        tc_soft();
        tc_misc();
        report_and_stop();
    end

    // whole run is about 5000 cycles
    initial begin
        repeat (40000) @(posedge core_clk);
        fail("watchdog expired");
        report_and_stop();
    end
endmodule

// ==== verilog/atsrf_pkg.sv ====
// constants for the attenuator shadow register forwarder
// assumes a 20 MHz core clock; all addresses are 8-bit serial addresses
package atsrf_pkg;
    localparam int ADDR_W     = 8;
    localparam int DATA_W     = 16;
    localparam int FRAME_BITS = 24;
    localparam int CNT_W      = 5;

    localparam logic [7:0] ADDR_SOFT_RST  = 8'h00;
    localparam logic [7:0] ADDR_LINK_RST  = 8'h03;
    localparam logic [7:0] ADDR_NOISE     = 8'h14;
    localparam logic [7:0] ADDR_WORD_LOW  = 8'h16;
    localparam logic [7:0] ADDR_WORD_MID  = 8'h17;
    localparam logic [7:0] ADDR_WORD_HIGH = 8'h18;
    localparam logic [7:0] ADDR_GAIN_A    = 8'h2A;
    localparam logic [7:0] ADDR_GAIN_B    = 8'h2B;
    localparam logic [7:0] ADDR_CODING    = 8'h46;

    localparam int SOFT_RST_BIT = 0;
    localparam int LINK_RST_BIT = 5;
    localparam int NOISE_BIT    = 0;
    localparam int CODING_BIT   = 2;

    localparam logic [15:0] WORD_LOW_RST   = 16'h0023;
    localparam logic [15:0] WORD_LOW_FORCE = 16'h0003;
    localparam logic [15:0] WORD_MID_RST   = 16'h0000;
    localparam logic [15:0] WORD_HIGH_RST  = 16'h0000;
    localparam logic [15:0] WORD_HIGH_MASK = 16'h00FF;
    localparam logic [15:0] GAIN_RST       = 16'h0000;

    localparam int WORD_BITS = 40;
    localparam int BIT_CNT_W = 6;
    localparam int OSC_CNT_W = 4;

    localparam int CLK_FREQ_KHZ  = 20000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int OSC_FREQ_KHZ  = 6000;
    // nearest whole half period, so the link runs near the target rate
    localparam int OSC_HALF_CYC  =
        (CLK_FREQ_KHZ + OSC_FREQ_KHZ) / (2 * OSC_FREQ_KHZ);
    localparam int HW_RST_MIN_NS  = 10;
    localparam int HW_RST_MIN_CYC =
        (HW_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_SHIFT = 3'b010,
        ST_RESET = 3'b100
    } atsrf_state_t;
endpackage

// ==== verilog/atsrf_serial_rx.sv ====
// serial programming port receiver: address byte then 16-bit data words
// assumes pins come from the host, asynchronous to core_clk
`timescale 1ns/1ps
module atsrf_serial_rx (
    input  wire logic                         core_clk,
    input  wire logic                         sys_rst,
    input  wire logic                         serial_clk,
    input  wire logic                         serial_en_n,
    input  wire logic                         serial_data,
    output logic                              wr_stb,
    output logic [atsrf_pkg::ADDR_W-1:0]      wr_addr,
    output logic [atsrf_pkg::DATA_W-1:0]      wr_data
);
    import atsrf_pkg::*;

    logic [2:0]              sync1_q;
    logic [2:0]              sync2_q;
    logic                    sclk_prev_q;
    logic [FRAME_BITS-1:0]   shift_q;
    logic [FRAME_BITS-1:0]   shift_d;
    logic [CNT_W-1:0]        cnt_q;
    logic                    first_q;
    logic                    stb_q;
    logic [ADDR_W-1:0]       addr_q;
    logic [DATA_W-1:0]       data_q;
    logic                    rise;

    // -----------------------------------------------------------------
    // pin synchronisers
    // -----------------------------------------------------------------
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_q     <= 3'h2;
            sync2_q     <= 3'h2;
            sclk_prev_q <= 1'b0;
        end else begin
            sync1_q     <= {serial_data, serial_en_n, serial_clk};
            sync2_q     <= sync1_q;
            sclk_prev_q <= sync2_q[0];
        end
    end

    assign rise    = sync2_q[0] & ~sclk_prev_q;
    assign shift_d = {shift_q[FRAME_BITS-2:0], sync2_q[2]};

    // -----------------------------------------------------------------
    // frame assembly
    // -----------------------------------------------------------------
    // later 16-bit groups in one window go to the next address
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            shift_q <= '0;
            cnt_q   <= '0;
            first_q <= 1'b1;
            stb_q   <= 1'b0;
            addr_q  <= '0;
            data_q  <= '0;
        end else begin
            stb_q <= 1'b0;
            if (sync2_q[1]) begin
                cnt_q   <= '0;
                first_q <= 1'b1;
            end else if (rise) begin
                shift_q <= shift_d;
                cnt_q   <= cnt_q + 1'b1;
                if (first_q && cnt_q == CNT_W'(FRAME_BITS - 1)) begin
                    addr_q  <= shift_d[FRAME_BITS-1:DATA_W];
                    data_q  <= shift_d[DATA_W-1:0];
                    stb_q   <= 1'b1;
                    first_q <= 1'b0;
                    cnt_q   <= '0;
                end else if (!first_q && cnt_q == CNT_W'(DATA_W - 1)) begin
                    addr_q <= addr_q + 1'b1; // R07
                    data_q <= shift_d[DATA_W-1:0];
                    stb_q  <= 1'b1;
                    cnt_q  <= '0;
                end
            end
        end
    end

    assign wr_stb  = stb_q;
    assign wr_addr = addr_q;
    assign wr_data = data_q;
endmodule

// ==== verilog/atsrf_top.sv ====
// configuration bank that forwards the 40-bit attenuator word on a link
// assumes host pins and the hardware reset pin are asynchronous inputs
`timescale 1ns/1ps
// How it works
// R01 - soft reset bit restores defaults, self-clears
// R02 - word low bits zero and one always one
// R03 - link clock and data idle without writes
// R04 - any trigger sends all forty bits
// R05 - unchanged write starts no transfer
// R06 - word merges new and held registers
// R07 - three registers accepted in one window
// R08 - gated oscillator runs only while shifting
// R09 - host leaves one microsecond between writes
// R10 - pin pulse or bit raises chip select
// R11 - link reset restores word defaults
// R12 - no link activity during link reset
// R13 - link reset bit holds reset state
// R14 - coding defaults offset binary, selectable
// R15 - per-channel digital gain defaults zero
// R16 - noise suppression defaults off, selectable
// R17 - start and write bits always high
// R18 - host writes whole register at once
// R19 - shift from bit zero, select low
// R20 - change during transfer queues another
module atsrf_top #(
    parameter int OSC_HALF = atsrf_pkg::OSC_HALF_CYC
) (
    input  wire logic                     core_clk,
    input  wire logic                     sys_rst,
    input  wire logic                     serial_clk,
    input  wire logic                     serial_en_n,
    input  wire logic                     serial_data,
    input  wire logic                     hardware_reset_pin_n,
    output logic                          attenuator_serial_clock,
    output logic                          attenuator_serial_data,
    output logic                          attenuator_chip_select,
    output logic                          attenuator_busy,
    output logic                          twos_complement_coding,
    output logic                          noise_suppress_en,
    output logic [atsrf_pkg::DATA_W-1:0]  digital_gain_a,
    output logic [atsrf_pkg::DATA_W-1:0]  digital_gain_b
);
    import atsrf_pkg::*;

    logic                   wr_stb;
    logic [ADDR_W-1:0]      wr_addr;
    logic [DATA_W-1:0]      wr_data;
    logic                   hw_sync1_q;
    logic                   hw_sync2_q;
    logic [3:0]             hw_low_cnt_q;
    logic                   hw_rst_q;
    logic                   soft_rst;
    logic                   bank_clr;
    logic                   link_rst;
    logic                   link_rst_bit_q;
    logic [DATA_W-1:0]      word_low_q;
    logic [DATA_W-1:0]      word_mid_q;
    logic [DATA_W-1:0]      word_high_q;
    logic [DATA_W-1:0]      gain_a_q;
    logic [DATA_W-1:0]      gain_b_q;
    logic                   coding_q;
    logic                   noise_q;
    logic                   word_chg;
    logic                   pending_q;
    logic                   start;
    logic                   done;
    atsrf_state_t           state_q;
    atsrf_state_t           state_d;
    logic [WORD_BITS-1:0]   shreg_q;
    logic [OSC_CNT_W-1:0]   osc_cnt_q;
    logic [BIT_CNT_W-1:0]   bit_cnt_q;
    logic                   sclk_q;
    logic                   cs_q;
    logic                   busy_q;

    atsrf_serial_rx i_atsrf_serial_rx (
        .core_clk    (core_clk),
        .sys_rst     (sys_rst),
        .serial_clk  (serial_clk),
        .serial_en_n (serial_en_n),
        .serial_data (serial_data),
        .wr_stb      (wr_stb),
        .wr_addr     (wr_addr),
        .wr_data     (wr_data)
    );

    // -----------------------------------------------------------------
    // hardware reset pin
    // -----------------------------------------------------------------
    // a pulse shorter than one clock period may slip between samples
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hw_sync1_q   <= 1'b1;
            hw_sync2_q   <= 1'b1;
            hw_low_cnt_q <= '0;
            hw_rst_q     <= 1'b0;
        end else begin
            hw_sync1_q <= hardware_reset_pin_n;
            hw_sync2_q <= hw_sync1_q;
            if (hw_sync2_q) begin
                hw_low_cnt_q <= '0;
            end else if (hw_low_cnt_q != 4'hF) begin
                hw_low_cnt_q <= hw_low_cnt_q + 1'b1;
            end
            hw_rst_q <= !hw_sync2_q &&
                (hw_low_cnt_q >= 4'(HW_RST_MIN_CYC - 1)); // R10
        end
    end

    assign soft_rst = wr_stb && wr_addr == ADDR_SOFT_RST &&
                      wr_data[SOFT_RST_BIT]; // R01
    assign bank_clr = soft_rst || hw_rst_q;
    assign link_rst = hw_rst_q || link_rst_bit_q; // R10

    // -----------------------------------------------------------------
    // register bank
    // -----------------------------------------------------------------
    // the soft reset bit has no storage, so it reads back cleared
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            link_rst_bit_q <= 1'b0;
        end else if (bank_clr) begin
            link_rst_bit_q <= 1'b0; // R01
        end else if (wr_stb && wr_addr == ADDR_LINK_RST) begin
            link_rst_bit_q <= wr_data[LINK_RST_BIT]; // R13
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            word_low_q  <= WORD_LOW_RST;
            word_mid_q  <= WORD_MID_RST;
            word_high_q <= WORD_HIGH_RST;
        end else if (bank_clr || link_rst) begin
            word_low_q  <= WORD_LOW_RST; // R11
            word_mid_q  <= WORD_MID_RST;
            word_high_q <= WORD_HIGH_RST;
        end else if (wr_stb) begin
            if (wr_addr == ADDR_WORD_LOW) begin
                word_low_q <= wr_data | WORD_LOW_FORCE; // R02 R17
            end
            if (wr_addr == ADDR_WORD_MID) begin
                word_mid_q <= wr_data;
            end
            if (wr_addr == ADDR_WORD_HIGH) begin
                word_high_q <= wr_data & WORD_HIGH_MASK;
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            gain_a_q <= GAIN_RST;
            gain_b_q <= GAIN_RST;
            coding_q <= 1'b0;
            noise_q  <= 1'b0;
        end else if (bank_clr) begin
            gain_a_q <= GAIN_RST;
            gain_b_q <= GAIN_RST;
            coding_q <= 1'b0; // R14
            noise_q  <= 1'b0;
        end else if (wr_stb) begin
            if (wr_addr == ADDR_GAIN_A) begin
                gain_a_q <= wr_data; // R15
            end
            if (wr_addr == ADDR_GAIN_B) begin
                gain_b_q <= wr_data; // R15
            end
            if (wr_addr == ADDR_CODING) begin
                coding_q <= wr_data[CODING_BIT]; // R14
            end
            if (wr_addr == ADDR_NOISE) begin
                noise_q <= wr_data[NOISE_BIT]; // R16
            end
        end
    end

    // -----------------------------------------------------------------
    // change detection and queueing
    // -----------------------------------------------------------------
    always_comb begin
        word_chg = 1'b0;
        if (wr_stb && !bank_clr && !link_rst) begin
            if (wr_addr == ADDR_WORD_LOW) begin
                word_chg = (wr_data | WORD_LOW_FORCE) != word_low_q; // R05
            end else if (wr_addr == ADDR_WORD_MID) begin
                word_chg = wr_data != word_mid_q; // R05
            end else if (wr_addr == ADDR_WORD_HIGH) begin
                word_chg = (wr_data & WORD_HIGH_MASK) != word_high_q;
            end
        end
    end

    assign start = state_q == ST_IDLE && pending_q && !link_rst &&
                   !bank_clr;
    assign done  = state_q == ST_SHIFT && sclk_q &&
                   osc_cnt_q == OSC_CNT_W'(OSC_HALF - 1) &&
                   bit_cnt_q == BIT_CNT_W'(WORD_BITS - 1);

    // a new change wins over the clear at start, so it is never lost
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pending_q <= 1'b0;
        end else if (bank_clr || link_rst) begin
            pending_q <= 1'b0;
        end else begin
            pending_q <= word_chg || (pending_q && !start); // R20
        end
    end

    // -----------------------------------------------------------------
    // forwarding state machine
    // -----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (link_rst) begin
                    state_d = ST_RESET;
                end else if (start) begin
                    state_d = ST_SHIFT; // R03
                end
            end
            ST_SHIFT: begin
                if (link_rst) begin
                    state_d = ST_RESET; // R12
                end else if (bank_clr || done) begin
                    state_d = ST_IDLE;
                end
            end
            ST_RESET: begin
                if (!link_rst) begin
                    state_d = ST_IDLE; // R13
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // -----------------------------------------------------------------
    // gated oscillator and shifter
    // -----------------------------------------------------------------
    // zero fill leaves the data line low once the word is out
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            shreg_q   <= '0;
            osc_cnt_q <= '0;
            bit_cnt_q <= '0;
            sclk_q    <= 1'b0;
        end else if (link_rst || bank_clr || state_q != ST_SHIFT) begin
            osc_cnt_q <= '0;
            bit_cnt_q <= '0;
            sclk_q    <= 1'b0; // R08 R12
            shreg_q   <= start ? {word_high_q[7:0], word_mid_q,
                                  word_low_q} : '0; // R04 R06
        end else if (osc_cnt_q == OSC_CNT_W'(OSC_HALF - 1)) begin
            osc_cnt_q <= '0;
            sclk_q    <= !sclk_q; // R08
            if (sclk_q) begin
                shreg_q   <= {1'b0, shreg_q[WORD_BITS-1:1]}; // R19
                bit_cnt_q <= done ? '0 : bit_cnt_q + 1'b1;
            end
        end else begin
            osc_cnt_q <= osc_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cs_q   <= 1'b1;
            busy_q <= 1'b0;
        end else begin
            cs_q   <= link_rst; // R10 R19
            busy_q <= state_d == ST_SHIFT;
        end
    end

    assign attenuator_serial_clock = sclk_q;
    assign attenuator_serial_data  = shreg_q[0];
    assign attenuator_chip_select  = cs_q;
    assign attenuator_busy         = busy_q;
    assign twos_complement_coding  = coding_q;
    assign noise_suppress_en       = noise_q;
    assign digital_gain_a          = gain_a_q;
    assign digital_gain_b          = gain_b_q;

    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    property p_soft_reset;
        soft_rst && !hw_rst_q |=> word_low_q == WORD_LOW_RST &&
            word_mid_q == WORD_MID_RST && !link_rst_bit_q &&
            state_q != ST_SHIFT;
    endproperty
    a_soft_reset: assert property (p_soft_reset) // R01
        else $error("soft reset left state behind");

    property p_forced_bits;
        (word_low_q & WORD_LOW_FORCE) == WORD_LOW_FORCE;
    endproperty
    a_forced_bits: assert property (p_forced_bits) // R02
        else $error("start or write bit dropped");

    property p_idle_quiet;
        state_q != ST_SHIFT |-> !attenuator_serial_clock &&
            !attenuator_serial_data;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) // R03
        else $error("link active outside a transfer");

    property p_forty_bits;
        $fell(state_q == ST_SHIFT) && !$past(link_rst) &&
            !$past(bank_clr) |-> $past(bit_cnt_q) ==
            BIT_CNT_W'(WORD_BITS - 1);
    endproperty
    a_forty_bits: assert property (p_forty_bits) // R04
        else $error("transfer ended early");

    property p_same_value;
        wr_stb && wr_addr == ADDR_WORD_LOW && !link_rst && !pending_q &&
            (wr_data | WORD_LOW_FORCE) == word_low_q &&
            state_q == ST_IDLE |=> !pending_q ##1 state_q == ST_IDLE;
    endproperty
    a_same_value: assert property (p_same_value) // R05
        else $error("unchanged write started a transfer");

    property p_word_snapshot;
        start && !word_chg |=> shreg_q == {word_high_q[7:0],
            word_mid_q, word_low_q};
    endproperty
    a_word_snapshot: assert property (p_word_snapshot) // R06
        else $error("word loaded wrongly");

    property p_osc_gate;
        $changed(attenuator_serial_clock) |-> $past(state_q) == ST_SHIFT;
    endproperty
    a_osc_gate: assert property (p_osc_gate) // R08
        else $error("oscillator ran outside a transfer");

    property p_cs_high;
        link_rst |=> attenuator_chip_select && state_q == ST_RESET;
    endproperty
    a_cs_high: assert property (p_cs_high) // R10
        else $error("chip select not raised by link reset");

    property p_word_defaults;
        link_rst |=> word_low_q == WORD_LOW_RST &&
            word_mid_q == WORD_MID_RST && word_high_q == WORD_HIGH_RST;
    endproperty
    a_word_defaults: assert property (p_word_defaults) // R11
        else $error("word not at defaults after link reset");

    property p_reset_quiet;
        state_q == ST_RESET |-> !attenuator_serial_clock &&
            !attenuator_serial_data;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) // R12
        else $error("link activity during reset");

    property p_hold_reset;
        link_rst_bit_q && state_q == ST_RESET |=> state_q == ST_RESET;
    endproperty
    a_hold_reset: assert property (p_hold_reset) // R13
        else $error("left reset while bit set");

    property p_digital_defaults;
        bank_clr |=> !twos_complement_coding && !noise_suppress_en &&
            digital_gain_a == GAIN_RST && digital_gain_b == GAIN_RST;
    endproperty
    a_digital_defaults: assert property (p_digital_defaults) // R14
        else $error("digital settings not at defaults");

    property p_start_cs_low;
        start |=> state_q == ST_SHIFT && !attenuator_chip_select &&
            attenuator_serial_data == word_low_q[0];
    endproperty
    a_start_cs_low: assert property (p_start_cs_low) // R19
        else $error("transfer start malformed");

    property p_queue_change;
        word_chg && state_q == ST_SHIFT |=> pending_q;
    endproperty
    a_queue_change: assert property (p_queue_change) // R20
        else $error("change during transfer lost");

    c_transfer: cover property (start ##1 state_q == ST_SHIFT);
    c_busy_write: cover property (word_chg && state_q == ST_SHIFT);
    c_link_reset: cover property ($rose(link_rst_bit_q));
    c_soft_reset: cover property (soft_rst);
endmodule
